/* hw/duwf_top.sv */
// Two-channel serial transceiver with queues behind an AHB-Lite slave
// Behaviour
// - Each channel moves bytes between bus and line
// - Only the selected channel takes part
// - Three address bits pick the register
// - Character length five to eight bits
// - Even, odd, no parity; 1, 1.5, 2 stops
// - 64-byte queues each way, programmable trigger levels
// - Flag break, idle, framing, overflow, parity
// - Flag transmit queue underflow
// - Bit rate is clock over sixteen times programmed divisor
// - Optional divide-by-four prescaler before divisor
// - Thresholds stop and restart remote transmitter
// - One read gives every channel's ready flags
// - Clear-to-send readable as modem status bit 4
// - Clear-to-send gates transmit only when enabled
// - Carrier detect level shown in modem status
// - Optionally any character other than XOFF resumes stopped transmitter
// - Reject start bits that do not persist
// - Loopback routes transmit data to receiver
// - Least significant bit sent first
// - Write data captured at end of write
// - Reset loads register defaults and drives line and RTS outputs high
`timescale 1ns/1ps
`default_nettype none
module duwf_top
	import duwf_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic chan_a_rx_data,
	output wire logic chan_a_tx_data,
	input wire logic chan_a_clear_to_send_n,
	input wire logic chan_a_carrier_detect_n,
	output wire logic chan_a_request_to_send_n,
	input wire logic chan_b_rx_data,
	output wire logic chan_b_tx_data,
	input wire logic chan_b_clear_to_send_n,
	input wire logic chan_b_carrier_detect_n,
	output wire logic chan_b_request_to_send_n
);
	logic wr_pend; // Write data phase pending
	logic [1:0] wr_region; // Region of pending write
	logic [2:0] wr_idx; // Register index of pending write
	logic sel; // Accepted word transfer in address phase
	logic rd_now; // Read accepted this cycle
	logic [1:0] rx_pin; // Serial inputs per channel
	logic [1:0] cts_n; // Clear-to-send per channel
	logic [1:0] cd_n; // Carrier detect per channel
	logic [1:0] tx_ready; // Transmit-ready flags
	logic [1:0] rx_ready; // Receive-ready flags
	logic [31:0] chan_rd [2]; // Read value per channel
	logic [1:0] tx_pin_q; // Serial outputs, flopped
	logic [1:0] rts_n_q; // Request-to-send outputs, flopped

	assign rx_pin = {chan_b_rx_data, chan_a_rx_data};
	assign cts_n = {chan_b_clear_to_send_n, chan_a_clear_to_send_n};
	assign cd_n = {chan_b_carrier_detect_n, chan_a_carrier_detect_n};
	assign chan_a_tx_data = tx_pin_q[0];
	assign chan_b_tx_data = tx_pin_q[1];
	assign chan_a_request_to_send_n = rts_n_q[0];
	assign chan_b_request_to_send_n = rts_n_q[1];

	// Only nonsequential and sequential word transfers are taken
	assign sel = hsel && htrans[1] && hready && hsize == 3'h2;
	assign rd_now = sel && !hwrite;

	// Address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_region <= 2'h0;
			wr_idx <= 3'h0;
		end else if (hready) begin
			wr_pend <= sel && hwrite;
			wr_region <= haddr[6:5];
			wr_idx <= haddr[4:2];
		end
	end

	// Zero-wait answers, always OKAY; read data for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (rd_now) begin
				if (haddr[6:5] == REGION_GLOBAL) begin
					// All channels' ready flags in one word
					hrdata <= (haddr[4:2] == REG_QUEUE_READY) ?
						{26'h0, rx_ready, 2'h0, tx_ready} : 32'h0;
				end else if (!haddr[6]) begin
					hrdata <= chan_rd[haddr[5]];
				end else begin
					hrdata <= 32'h0;
				end
			end
		end
	end

	for (genvar g = 0; g < 2; g++) begin : ch
		logic wr; // Write to this channel in data phase
		logic rd; // Read of this channel in address phase
		logic [7:0] line_ctrl;
		logic [15:0] divisor;
		logic [21:0] modem_ctrl;
		logic [7:0] enhanced_feature_register;
		logic [7:0] flow_threshold_register;
		logic [7:0] txq [64]; // Transmit queue storage
		logic [10:0] rxq [64]; // Receive entries: break, frame, parity, data
		logic [5:0] tx_wp, tx_rp, rx_wp, rx_rp;
		logic [6:0] tx_cnt, rx_cnt;
		logic tx_push, tx_pop, rx_push, rx_pop;
		logic [1:0] pre_cnt; // Prescaler count
		logic [15:0] div_cnt; // Divisor count
		logic tick; // Oversample tick, 16 per bit
		duwf_tx_state_t tx_state;
		logic [4:0] tx_sub;
		logic [2:0] tx_bit;
		logic [7:0] tx_shift;
		logic tx_par;
		logic tx_level; // Internal transmit line level
		logic tx_load; // Transmitter takes a character
		logic [7:0] tx_char; // Character being taken
		logic tx_hold; // Flow control holds transmitter
		logic xoff_req, xon_req; // Flow characters to send
		logic sw_stopped; // Remote asked us to pause
		logic halted; // We asked the remote to pause
		logic underflow, overrun;
		duwf_rx_state_t rx_state;
		logic [4:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_par_bit;
		logic rx_prev;
		logic rx_in; // Receiver input after loopback selection
		logic rx_done; // Stop bit sampled
		logic [7:0] rx_data; // Aligned received character
		logic [7:0] len_mask; // Data bits in use
		logic rx_perr, rx_ferr, rx_brk;
		logic [10:0] rx_head;
		logic [4:0] stop_end;
		logic [6:0] rx_trig, tx_trig;

		assign wr = wr_pend && wr_region == 2'(g);
		assign rd = rd_now && haddr[6:5] == 2'(g);
		// Length 5..8 selects the active data bits
		assign len_mask = 8'hff >> (2'h3 - line_ctrl[LC_LEN +: 2]);

		// Software registers; data taken as the write completes
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				line_ctrl <= LINE_CTRL_RST;
				divisor <= DIVISOR_RST;
				modem_ctrl <= MODEM_CTRL_RST;
				enhanced_feature_register <= EFR_RST;
				flow_threshold_register <= TCR_RST;
			end else if (wr) begin
				case (wr_idx)
					REG_LINE_CTRL: line_ctrl <= hwdata[7:0];
					REG_DIVISOR: divisor <= hwdata[15:0];
					REG_MODEM_CTRL: modem_ctrl <= hwdata[21:0];
					REG_EFR: enhanced_feature_register <= hwdata[7:0];
					REG_TCR: flow_threshold_register <= hwdata[7:0];
					default: ;
				endcase
			end
		end

		// Queue strobes; full pushes of software are dropped
		assign tx_push = wr && wr_idx == REG_DATA && tx_cnt != QUEUE_DEPTH;
		assign tx_pop = tx_load && !xoff_req && !xon_req;
		assign rx_pop = rd && haddr[4:2] == REG_DATA && rx_cnt != 7'h0;
		assign rx_head = rxq[rx_rp];

		// Queue storage
		always_ff @(posedge hclk) begin
			if (tx_push) begin
				txq[tx_wp] <= hwdata[7:0];
			end
			if (rx_push) begin
				rxq[rx_wp] <= {rx_brk, rx_ferr, rx_perr, rx_data};
			end
		end

		// Queue pointers and counts
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				tx_wp <= 6'h0;
				tx_rp <= 6'h0;
				rx_wp <= 6'h0;
				rx_rp <= 6'h0;
				tx_cnt <= 7'h0;
				rx_cnt <= 7'h0;
			end else begin
				tx_wp <= tx_wp + 6'(tx_push);
				tx_rp <= tx_rp + 6'(tx_pop);
				rx_wp <= rx_wp + 6'(rx_push);
				rx_rp <= rx_rp + 6'(rx_pop);
				tx_cnt <= tx_cnt + 7'(tx_push) - 7'(tx_pop);
				rx_cnt <= rx_cnt + 7'(rx_push) - 7'(rx_pop);
			end
		end

		// Bit-rate ticks: clock / (1 or 4) / divisor
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				pre_cnt <= 2'h0;
				div_cnt <= 16'h0;
				tick <= 1'b0;
			end else begin
				pre_cnt <= pre_cnt + 2'h1;
				tick <= 1'b0;
				// Prescaler passes one clock in four
				if (!modem_ctrl[MC_PRESCALE] || pre_cnt == 2'h3) begin
					if (div_cnt + 16'h1 >= divisor) begin
						div_cnt <= 16'h0;
						tick <= 1'b1;
					end else begin
						div_cnt <= div_cnt + 16'h1;
					end
				end
			end
		end

		// Transmit gating: auto clear-to-send and remote pause
		assign tx_hold = (enhanced_feature_register[EF_AUTO_CTS] && cts_n[g]) || sw_stopped;
		assign tx_char = xoff_req ? XOFF_CHAR : (xon_req ? XON_CHAR : txq[tx_rp]);
		assign tx_load = tx_state == TX_IDLE &&
			(xoff_req || xon_req || (!tx_hold && tx_cnt != 7'h0));
		// Stop length: 1, or 1.5 for five bits else 2
		assign stop_end = !line_ctrl[LC_STOP] ? TICK_BIT_END :
			(line_ctrl[LC_LEN +: 2] == 2'h0 ? TICK_STOP15_END : TICK_STOP2_END);

		// Transmitter sequence
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				tx_state <= TX_IDLE;
				tx_sub <= 5'h0;
				tx_bit <= 3'h0;
				tx_shift <= 8'h0;
				tx_par <= 1'b0;
				tx_level <= 1'b1;
			end else begin
				case (tx_state)
					TX_IDLE: begin
						if (tx_load) begin
							tx_shift <= tx_char & len_mask;
							// Even parity equals the data XOR
							tx_par <= ^(tx_char & len_mask) ^ !line_ctrl[LC_PAR_EVEN];
							tx_level <= 1'b0;
							tx_sub <= 5'h0;
							tx_state <= TX_START;
						end
					end
					TX_START: begin
						if (tick) begin
							tx_sub <= tx_sub + 5'h1;
							if (tx_sub == TICK_BIT_END) begin
								tx_sub <= 5'h0;
								tx_bit <= 3'h0;
								tx_level <= tx_shift[0];
								tx_state <= TX_DATA;
							end
						end
					end
					TX_DATA: begin
						if (tick) begin
							tx_sub <= tx_sub + 5'h1;
							if (tx_sub == TICK_BIT_END) begin
								tx_sub <= 5'h0;
								if (tx_bit == 3'h4 + 3'(line_ctrl[LC_LEN +: 2])) begin
									tx_level <= line_ctrl[LC_PAR_EN] ? tx_par : 1'b1;
									tx_state <= line_ctrl[LC_PAR_EN] ? TX_PAR : TX_STOP;
								end else begin
									tx_bit <= tx_bit + 3'h1;
									tx_shift <= tx_shift >> 1;
									tx_level <= tx_shift[1];
								end
							end
						end
					end
					TX_PAR: begin
						if (tick) begin
							tx_sub <= tx_sub + 5'h1;
							if (tx_sub == TICK_BIT_END) begin
								tx_sub <= 5'h0;
								tx_level <= 1'b1;
								tx_state <= TX_STOP;
							end
						end
					end
					TX_STOP: begin
						if (tick) begin
							tx_sub <= tx_sub + 5'h1;
							if (tx_sub == stop_end) begin
								tx_sub <= 5'h0;
								tx_state <= TX_IDLE;
							end
						end
					end
					default: tx_state <= TX_IDLE;
				endcase
			end
		end

		// Pins: loopback keeps line at mark, otherwise break forces space
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				tx_pin_q[g] <= 1'b1;
				rts_n_q[g] <= 1'b1;
			end else begin
				tx_pin_q[g] <= modem_ctrl[MC_LOOP] ||
					(!line_ctrl[LC_BREAK] && tx_level);
				// Auto RTS releases while we hold the remote off
				rts_n_q[g] <= !modem_ctrl[MC_RTS] ||
					(enhanced_feature_register[EF_AUTO_RTS] && halted);
			end
		end

		// Threshold flow: halt at or above upper level, resume at or below lower
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				halted <= 1'b0;
				xoff_req <= 1'b0;
				xon_req <= 1'b0;
			end else begin
				if (!halted && rx_cnt >= {1'b0, flow_threshold_register[3:0], 2'h0}) begin
					halted <= 1'b1;
					xoff_req <= enhanced_feature_register[EF_SW_FLOW];
					xon_req <= 1'b0;
				end else if (halted && rx_cnt <= {1'b0, flow_threshold_register[7:4], 2'h0}) begin
					halted <= 1'b0;
					xon_req <= enhanced_feature_register[EF_SW_FLOW];
					xoff_req <= 1'b0;
				end else if (tx_load) begin
					xoff_req <= 1'b0;
					xon_req <= xoff_req ? xon_req : 1'b0;
				end
			end
		end

		// Receiver input, loopback taken from transmit side
		assign rx_in = modem_ctrl[MC_LOOP] ?
			(!line_ctrl[LC_BREAK] && tx_level) : rx_pin[g];
		assign rx_data = rx_shift >> (2'h3 - line_ctrl[LC_LEN +: 2]);
		assign rx_done = rx_state == RX_STOP && tick && rx_sub == TICK_BIT_END;
		assign rx_perr = line_ctrl[LC_PAR_EN] &&
			((^rx_data ^ !line_ctrl[LC_PAR_EVEN]) != rx_par_bit);
		assign rx_ferr = !rx_in;
		assign rx_brk = !rx_in && rx_data == 8'h0 &&
			!(line_ctrl[LC_PAR_EN] && rx_par_bit);
		// Flow characters are consumed, not queued
		assign rx_push = rx_done && rx_cnt != QUEUE_DEPTH &&
			!(enhanced_feature_register[EF_SW_FLOW] && (rx_data == XON_CHAR || rx_data == XOFF_CHAR));

		// Receiver sequence, centre sampling at 16 ticks per bit
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				rx_state <= RX_IDLE;
				rx_sub <= 5'h0;
				rx_bit <= 3'h0;
				rx_shift <= 8'h0;
				rx_par_bit <= 1'b0;
				rx_prev <= 1'b1;
			end else begin
				rx_prev <= rx_in;
				case (rx_state)
					RX_IDLE: begin
						if (rx_prev && !rx_in) begin
							rx_sub <= 5'h0;
							rx_state <= RX_START;
						end
					end
					RX_START: begin
						if (tick) begin
							rx_sub <= rx_sub + 5'h1;
							if (rx_sub == TICK_HALF) begin
								rx_sub <= 5'h0;
								rx_bit <= 3'h0;
								// Line back high at mid start: false start
								rx_state <= rx_in ? RX_IDLE : RX_DATA;
							end
						end
					end
					RX_DATA: begin
						if (tick) begin
							rx_sub <= rx_sub + 5'h1;
							if (rx_sub == TICK_BIT_END) begin
								rx_sub <= 5'h0;
								rx_shift <= {rx_in, rx_shift[7:1]};
								rx_bit <= rx_bit + 3'h1;
								if (rx_bit == 3'h4 + 3'(line_ctrl[LC_LEN +: 2])) begin
									rx_state <= line_ctrl[LC_PAR_EN] ? RX_PAR : RX_STOP;
								end
							end
						end
					end
					RX_PAR: begin
						if (tick) begin
							rx_sub <= rx_sub + 5'h1;
							if (rx_sub == TICK_BIT_END) begin
								rx_sub <= 5'h0;
								rx_par_bit <= rx_in;
								rx_state <= RX_STOP;
							end
						end
					end
					RX_STOP: begin
						if (tick) begin
							rx_sub <= rx_sub + 5'h1;
							if (rx_sub == TICK_BIT_END) begin
								rx_sub <= 5'h0;
								rx_state <= RX_IDLE;
							end
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end

		// Remote pause from received flow characters
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				sw_stopped <= 1'b0;
			end else if (rx_done && enhanced_feature_register[EF_SW_FLOW]) begin
				if (rx_data == XOFF_CHAR) begin
					sw_stopped <= 1'b1;
				end else if (rx_data == XON_CHAR || enhanced_feature_register[EF_XON_ANY]) begin
					sw_stopped <= 1'b0;
				end
			end
		end

		// Sticky errors, cleared by status read; a new event wins
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				overrun <= 1'b0;
				underflow <= 1'b0;
			end else begin
				overrun <= (rx_done && rx_cnt == QUEUE_DEPTH) ||
					(overrun && !(rd && haddr[4:2] == REG_LINE_STATUS));
				// Queue ran dry at the end of a character
				underflow <= (tx_state == TX_STOP && tick &&
					tx_sub == stop_end && tx_cnt == 7'h0) ||
					(underflow && !(rd && haddr[4:2] == REG_LINE_STATUS));
			end
		end

		// Ready flags against trigger levels
		assign rx_trig = (modem_ctrl[MC_RX_TRIG +: 6] == 6'h0) ? 7'h1 :
			{1'b0, modem_ctrl[MC_RX_TRIG +: 6]};
		assign tx_trig = (modem_ctrl[MC_TX_TRIG +: 6] == 6'h0) ? 7'h1 :
			{1'b0, modem_ctrl[MC_TX_TRIG +: 6]};
		assign rx_ready[g] = rx_cnt >= rx_trig;
		assign tx_ready[g] = QUEUE_DEPTH - tx_cnt >= tx_trig;

		// Read values of this channel
		always_comb begin
			chan_rd[g] = 32'h0;
			case (haddr[4:2])
				REG_DATA: chan_rd[g] = {24'h0, rx_head[7:0]};
				REG_LINE_CTRL: chan_rd[g] = {24'h0, line_ctrl};
				REG_DIVISOR: chan_rd[g] = {16'h0, divisor};
				REG_LINE_STATUS: begin
					chan_rd[g][LS_RX_AVAIL] = rx_cnt != 7'h0;
					chan_rd[g][LS_OVERRUN] = overrun;
					chan_rd[g][LS_PARITY] = rx_cnt != 7'h0 && rx_head[8];
					chan_rd[g][LS_FRAMING] = rx_cnt != 7'h0 && rx_head[9];
					chan_rd[g][LS_BREAK] = rx_cnt != 7'h0 && rx_head[10];
					chan_rd[g][LS_TX_EMPTY] = tx_cnt == 7'h0;
					chan_rd[g][LS_TX_IDLE] = tx_cnt == 7'h0 && tx_state == TX_IDLE;
					chan_rd[g][LS_RX_IDLE] = rx_state == RX_IDLE && rx_in;
					chan_rd[g][LS_UNDERFLOW] = underflow;
				end
				REG_MODEM_CTRL: chan_rd[g] = {10'h0, modem_ctrl};
				REG_EFR: chan_rd[g] = {24'h0, enhanced_feature_register};
				REG_TCR: chan_rd[g] = {24'h0, flow_threshold_register};
				REG_MSR: begin
					chan_rd[g][MS_CTS] = !cts_n[g];
					chan_rd[g][MS_CD] = !cd_n[g];
				end
				default: chan_rd[g] = 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

/* pkg/duwf_pkg.sv */
// Constants and types shared by the dual serial channel block
package duwf_pkg;
	// Address regions (haddr[6:5]) and register index (haddr[4:2])
	localparam logic [1:0] REGION_GLOBAL = 2'h2;
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_LINE_CTRL = 3'h1;
	localparam logic [2:0] REG_DIVISOR = 3'h2;
	localparam logic [2:0] REG_LINE_STATUS = 3'h3;
	localparam logic [2:0] REG_MODEM_CTRL = 3'h4;
	localparam logic [2:0] REG_EFR = 3'h5;
	localparam logic [2:0] REG_TCR = 3'h6;
	localparam logic [2:0] REG_MSR = 3'h7;
	localparam logic [2:0] REG_QUEUE_READY = 3'h0;
	// Line control fields
	localparam int LC_LEN = 0;
	localparam int LC_STOP = 2;
	localparam int LC_PAR_EN = 3;
	localparam int LC_PAR_EVEN = 4;
	localparam int LC_BREAK = 6;
	// Modem control fields
	localparam int MC_RTS = 1;
	localparam int MC_LOOP = 4;
	localparam int MC_PRESCALE = 7;
	localparam int MC_RX_TRIG = 8;
	localparam int MC_TX_TRIG = 16;
	// Enhanced feature fields
	localparam int EF_SW_FLOW = 4;
	localparam int EF_XON_ANY = 5;
	localparam int EF_AUTO_RTS = 6;
	localparam int EF_AUTO_CTS = 7;
	// Line status and modem status fields
	localparam int LS_RX_AVAIL = 0;
	localparam int LS_OVERRUN = 1;
	localparam int LS_PARITY = 2;
	localparam int LS_FRAMING = 3;
	localparam int LS_BREAK = 4;
	localparam int LS_TX_EMPTY = 5;
	localparam int LS_TX_IDLE = 6;
	localparam int LS_RX_IDLE = 7;
	localparam int LS_UNDERFLOW = 8;
	localparam int MS_CTS = 4;
	localparam int MS_CD = 7;
	// Queue-ready fields
	localparam int QR_TX = 0;
	localparam int QR_RX = 4;
	// Reset values
	localparam logic [7:0] LINE_CTRL_RST = 8'h03;
	localparam logic [15:0] DIVISOR_RST = 16'h0001;
	localparam logic [21:0] MODEM_CTRL_RST = 22'h010100;
	localparam logic [7:0] EFR_RST = 8'h00;
	localparam logic [7:0] TCR_RST = 8'h4c;
	// Flow characters
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] XOFF_CHAR = 8'h13;
	// Timing in oversample ticks, queue depth and state types
	localparam logic [4:0] TICK_BIT_END = 5'h0f;
	localparam logic [4:0] TICK_HALF = 5'h07;
	localparam logic [4:0] TICK_STOP15_END = 5'h17;
	localparam logic [4:0] TICK_STOP2_END = 5'h1f;
	localparam logic [6:0] QUEUE_DEPTH = 7'h40;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		duwf_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		duwf_rx_state_t;
endpackage

/* verif/duwf_top_assertions.sv */
// Bus and serial line checks bound to the dual channel top
`timescale 1ns/1ps
`default_nettype none
module duwf_top_assertions
	import duwf_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic chan_a_tx_data,
	input wire logic chan_b_tx_data,
	input wire logic chan_a_clear_to_send_n,
	input wire logic chan_a_request_to_send_n,
	input wire logic chan_b_request_to_send_n
);
	// Word read accepted in its address phase
	wire logic rd_take = hsel && htrans[1] && hready && !hwrite
		&& hsize == 3'h2;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (!hresp)
		else $error("bus response not okay");
	a_ready_high: assert property ($past(hresetn) |-> hreadyout)
		else $error("slave not ready after reset");
	a_reset_idle: assert property ($rose(hresetn) |->
		chan_a_tx_data && chan_b_tx_data
		&& chan_a_request_to_send_n && chan_b_request_to_send_n)
		else $error("lines not idle out of reset");
	a_start_len: assert property ($fell(chan_a_tx_data) |=>
		(!chan_a_tx_data)[*8] ##1 (!chan_a_tx_data)[*7])
		else $error("start bit shorter than sixteen clocks");
	a_bit_hold: assert property ($changed(chan_a_tx_data) |=>
		$stable(chan_a_tx_data)[*8])
		else $error("serial level held too briefly");
	a_hrdata_hold: assert property (!$past(rd_take) |->
		$stable(hrdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (rd_take
		&& haddr[6:5] == 2'h3 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_msr_level: assert property (rd_take
		&& haddr[6:2] == {2'h0, REG_MSR}
		&& $past(chan_a_clear_to_send_n, 3) == chan_a_clear_to_send_n
		|=> hrdata[MS_CTS] == !$past(chan_a_clear_to_send_n))
		else $error("modem status does not show clear to send");
endmodule
bind duwf_top duwf_top_assertions chk (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp, .hrdata,
	.chan_a_tx_data, .chan_b_tx_data, .chan_a_clear_to_send_n,
	.chan_a_request_to_send_n, .chan_b_request_to_send_n);
`default_nettype wire

/* verif/duwf_modem_model.sv */
// Remote serial device: frames bytes in and out, drives handshake lines
`timescale 1ns/1ps
`default_nettype none
module duwf_modem_model (
	input wire logic hclk,
	input wire logic line_in,
	output logic line_out,
	output logic cts_n,
	output logic cd_n
);
	// Idle line high, handshakes inactive
	initial begin
		line_out = 1'b1;
		cts_n = 1'b1;
		cd_n = 1'b1;
	end
	// Send start, eight data bits first bit lowest, chosen stop level
	task automatic send(input logic [7:0] b, input int bt, input logic sv);
		logic [9:0] f;
		f = {sv, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (bt) @(posedge hclk);
		end
		line_out <= 1'b1;
		repeat (bt) @(posedge hclk);
	endtask
	// Catch a start, then sample eight bit centres
	task automatic recv(output logic [7:0] b, input int bt);
		int n;
		b = 8'h00;
		n = 0;
		while (line_in === 1'b1 && n < 4000) begin
			@(posedge hclk);
			n++;
		end
		repeat (bt / 2) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(posedge hclk);
			b[i] = line_in;
		end
	endtask
endmodule
`default_nettype wire

/* verif/duwf_top_tb_top.sv */
// Self-checking bench for the dual channel top
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end end
module duwf_top_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	wire logic hreadyout;
	wire logic [31:0] hrdata;
	wire logic tx_a, rx_a, cts_a, cd_a, tx_b, rx_b, cts_b, cd_b, rts_a;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] got;
	logic [31:0] rv;
	logic [31:0] r_off [5] = '{32'h04, 32'h08, 32'h10, 32'h14, 32'h18};
	logic [31:0] r_val [5] = '{32'h03, 32'h01, 32'h010100, 32'h0, 32'h4c};
	logic [7:0] fmt [3] = '{8'h03, 8'h18, 8'h08};
	logic [7:0] dat [3] = '{8'ha5, 8'h15, 8'h15};
	logic [7:0] ser [3] = '{8'ha5, 8'hf5, 8'hd5};
	always #12.5 hclk = ~hclk;
	duwf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(), .hrdata(hrdata), .chan_a_rx_data(rx_a),
		.chan_a_tx_data(tx_a), .chan_a_clear_to_send_n(cts_a),
		.chan_a_carrier_detect_n(cd_a), .chan_a_request_to_send_n(rts_a),
		.chan_b_rx_data(rx_b), .chan_b_tx_data(tx_b),
		.chan_b_clear_to_send_n(cts_b), .chan_b_carrier_detect_n(cd_b),
		.chan_b_request_to_send_n());
	duwf_modem_model modem_a (.hclk(hclk), .line_in(tx_a),
		.line_out(rx_a), .cts_n(cts_a), .cd_n(cd_a));
	duwf_modem_model modem_b (.hclk(hclk), .line_in(tx_b),
		.line_out(rx_b), .cts_n(cts_b), .cd_n(cd_b));
	// Print counts and verdict, then stop
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Wait for the slave to sample ready high, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
	endtask
	// One single word transfer: address phase, then data phase
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rv = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	// Read and compare under a mask
	task automatic rd(input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK($sformatf("reg %h", a), e, rv & m)
	endtask
	// Cut a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		for (int i = 0; i < 5; i++) begin
			rd(r_off[i], 32'hffffffff, r_val[i]);
			rd(r_off[i] | 32'h20, 32'hffffffff, r_val[i]);
		end
		wr(32'h60, 32'hffff);
		rd(32'h60, 32'hffffffff, 32'h0);
		rd(32'h44, 32'hffffffff, 32'h0);
		$display("reset values done");
		for (int k = 0; k < 2; k++) begin
			modem_a.cts_n <= k[0];
			modem_a.cd_n <= !k[0];
			modem_b.cts_n <= !k[0];
			modem_b.cd_n <= k[0];
			repeat (8) @(posedge hclk);
			rd(32'h1c, 32'h90, k[0] ? 32'h80 : 32'h10);
			rd(32'h3c, 32'h90, k[0] ? 32'h10 : 32'h80);
		end
		$display("modem status done");
		for (int i = 0; i < 3; i++) begin
			wr(32'h04, {24'h0, fmt[i]});
			wr(32'h00, {24'h0, dat[i]});
			modem_a.recv(got, 16);
			`CHK("tx char", ser[i], got)
			repeat (40) @(posedge hclk);
		end
		wr(32'h04, 32'h03);
		wr(32'h08, 32'h02);
		wr(32'h10, 32'h010180);
		wr(32'h00, 32'h3c);
		modem_a.recv(got, 128);
		`CHK("tx prescaled", 8'h3c, got)
		repeat (300) @(posedge hclk);
		wr(32'h08, 32'h01);
		wr(32'h10, 32'h010100);
		// Last character ended with an empty queue; the read clears it
		rd(32'h0c, 32'h100, 32'h100);
		rd(32'h0c, 32'h100, 32'h0);
		$display("transmit done");
		modem_b.send(8'h5a, 16, 1'b1);
		rd(32'h40, 32'h33, 32'h23);
		rd(32'h2c, 32'h09, 32'h01);
		rd(32'h20, 32'hff, 32'h5a);
		rd(32'h2c, 32'h01, 32'h00);
		modem_b.send(8'h96, 16, 1'b0);
		rd(32'h2c, 32'h09, 32'h09);
		rd(32'h20, 32'hff, 32'h96);
		modem_b.line_out <= 1'b0;
		repeat (4) @(posedge hclk);
		modem_b.line_out <= 1'b1;
		repeat (300) @(posedge hclk);
		rd(32'h2c, 32'h01, 32'h00);
		$display("receive done");
		// Halt at four entries, resume when empty, auto RTS on
		wr(32'h18, 32'h01);
		wr(32'h14, 32'h40);
		wr(32'h10, 32'h010112);
		for (int i = 0; i < 4; i++) begin
			wr(32'h00, 32'hc3 + i);
		end
		// Inside the first start bit: pin must still be at mark
		repeat (4) @(posedge hclk);
		`CHK("loop tx pin", 1'b1, tx_a)
		`CHK("rts on", 1'b0, rts_a)
		repeat (700) @(posedge hclk);
		`CHK("rts held off", 1'b1, rts_a)
		for (int i = 0; i < 4; i++) begin
			rd(32'h00, 32'hff, 32'hc3 + i);
		end
		repeat (3) @(posedge hclk);
		`CHK("rts resumed", 1'b0, rts_a)
		wr(32'h10, 32'h010100);
		$display("loopback done");
		wr(32'h14, 32'h80);
		wr(32'h00, 32'h66);
		// A free transmitter would be in a space bit here
		repeat (80) @(posedge hclk);
		`CHK("held by cts", 1'b1, tx_a)
		modem_a.cts_n <= 1'b0;
		modem_a.recv(got, 16);
		`CHK("released by cts", 8'h66, got)
		$display("flow control done");
		give_verdict();
	end
endmodule
`default_nettype wire
